// ===== inc/lcd_drv_params.svh
// constants for the multiplexed lcd segment driver
`ifndef LCD_DRV_PARAMS_SVH
`define LCD_DRV_PARAMS_SVH
`define CLK_HZ 40000000
`define FRAME_HZ 50
`define NUM_SEG 40
`define NUM_BP 3
`define SLOT_PER_FRAME 6
`define DEV_ADDR 8'h74
`define ADDR_BITS 8
`define LVL_0V5 2'h0
`define LVL_2V0 2'h1
`define LVL_3V5 2'h2
`define LVL_5V0 2'h3
`endif

// ===== inc/lcd_drv_pkg.sv
// types for the multiplexed lcd segment driver
package lcd_drv_pkg;
    typedef logic [1:0] level_t;
    typedef struct packed {
        logic clk_line;
        logic data_line;
    } bus_in_t;
    typedef struct packed {
        logic data_out;
        logic data_oe;
    } bus_out_t;
    typedef enum logic [1:0] {
        RX_ADDR = 2'b00,
        RX_DATA = 2'b01,
        RX_ACK = 2'b11,
        RX_SKIP = 2'b10
    } rx_state_t;
endpackage : lcd_drv_pkg

// ===== verilog/seg_wave.sv
// one segment output: drive level per slot from three stored bits
`timescale 1ns/100ps
`include "lcd_drv_params.svh"
module seg_wave (
    input wire logic clk, // system clock
    input wire logic resetn, // sync reset, active low
    input wire logic [2:0] seg_on, // on/off of the three segments
    input wire logic [1:0] bp_idx, // backplane owning this slot pair
    input wire logic inv_half, // second half of the slot pair
    output lcd_drv_pkg::level_t level // registered drive level
);
    import lcd_drv_pkg::*;
    // lit segment: opposite outer level to backplane select; unlit: inner
    wire logic sel_on = seg_on[bp_idx];
    wire level_t next_level = sel_on ?
        (inv_half ? `LVL_0V5 : `LVL_5V0) :
        (inv_half ? `LVL_2V0 : `LVL_3V5);
    always_ff @(posedge clk) begin
        if (!resetn) begin
            level <= `LVL_0V5;
        end else begin
            level <= next_level;
        end
    end
endmodule : seg_wave

// ===== verilog/lcd_seg_driver.sv
// multiplexed lcd segment driver: two-wire bus receiver and waveforms
// Behaviour
// - display runs from stored copy forever, no refresh needed
// - frame timing from own clock, near 50 Hz
// - three staircase backplanes spaced one third of a frame
// - all steps use four levels, two-bit level index
// - forty segment outputs, each multiplexed over three backplanes
// - segment level sequence chosen from its three stored bits
// - power-up shows every segment and annunciator lit
// - driver acts only on messages carrying its own address
// - addressed receiver acknowledges each byte by pulling data low
`timescale 1ns/100ps
`include "lcd_drv_params.svh"
module lcd_seg_driver #(
    parameter int NSEG = `NUM_SEG, // segment outputs
    parameter int FRAME_HZ = `FRAME_HZ // frame rate
) (
    input wire logic clk, // system clock, 40 MHz
    input wire logic resetn, // sync reset, active low
    input lcd_drv_pkg::bus_in_t bus_in, // serial clock and data pins
    output lcd_drv_pkg::bus_out_t bus_out, // data pull-low drive
    output lcd_drv_pkg::level_t bp_level [`NUM_BP], // backplane levels
    output lcd_drv_pkg::level_t seg_level [NSEG] // segment levels
);
    import lcd_drv_pkg::*;
    localparam int NBITS = 3 * NSEG;
    localparam int SLOT_CYC = `CLK_HZ / (FRAME_HZ * `SLOT_PER_FRAME);
    localparam int BYTES = (NBITS + 7) / 8;
    // byte counter is eight bits wide, slot counter needs two codes at least
    if (NSEG < 1 || BYTES > 255 || SLOT_CYC < 2) begin : g_bad_param
        $error("lcd_seg_driver: unsupported parameters");
    end

    // ----------------------------------------
    // pin synchronisers and edge detection
    // ----------------------------------------
    logic [1:0] sck_s;
    logic [1:0] sda_s;
    logic sck_d;
    logic sda_d;
    always_ff @(posedge clk) begin
        if (!resetn) begin
            sck_s <= 2'h3;
            sda_s <= 2'h3;
            sck_d <= 1'b1;
            sda_d <= 1'b1;
        end else begin
            sck_s <= {sck_s[0], bus_in.clk_line};
            sda_s <= {sda_s[0], bus_in.data_line};
            sck_d <= sck_s[1];
            sda_d <= sda_s[1];
        end
    end
    wire logic sck = sck_s[1];
    wire logic sda = sda_s[1];
    wire logic sck_rise = sck & ~sck_d;
    wire logic sck_fall = ~sck & sck_d;
    // start: data falls while clock high; stop: data rises while clock high
    // clock must already have stood high a cycle: our own ack edges sit
    // close to a clock edge and must not pass for start or stop
    wire logic start_ev = sck & sck_d & sda_d & ~sda;
    wire logic stop_ev = sck & sck_d & ~sda_d & sda;

    // ----------------------------------------
    // bus receiver
    // ----------------------------------------
    rx_state_t state;
    rx_state_t next_state;
    logic [7:0] shreg;
    logic [2:0] bitcnt;
    logic [7:0] bytecnt;
    logic addr_ok;
    logic msg_done;
    logic [NBITS-1:0] shadow;
    logic [NBITS-1:0] active;
    logic ack_drive;
    wire logic byte_done = sck_rise && bitcnt == 3'h7;
    wire logic [7:0] byte_val = {shreg[6:0], sda};
    wire logic addr_match = byte_val == `DEV_ADDR;
    wire logic full_msg = bytecnt == 8'(BYTES);

    // receiver state transitions
    always_comb begin
        next_state = state;
        unique case (state)
            RX_ADDR: if (byte_done) begin
                next_state = addr_match ? RX_ACK : RX_SKIP;
            end
            RX_DATA: if (byte_done) begin
                next_state = RX_ACK;
            end
            RX_ACK: if (sck_fall && ack_drive) begin
                next_state = RX_DATA;
            end
            RX_SKIP: next_state = RX_SKIP; // foreign message ignored
        endcase
        if (start_ev || stop_ev) begin
            next_state = RX_ADDR;
        end
    end

    // bit and byte counting, shadow fill
    always_ff @(posedge clk) begin
        if (!resetn) begin
            state <= RX_ADDR;
            shreg <= 8'h00;
            bitcnt <= 3'h0;
            bytecnt <= 8'h00;
            shadow <= '1;
        end else begin
            state <= next_state;
            if (start_ev || stop_ev) begin
                bitcnt <= 3'h0;
                bytecnt <= 8'h00;
            end else if (sck_rise && state != RX_ACK) begin
                shreg <= byte_val;
                bitcnt <= bitcnt + 3'h1;
            end
            if (state == RX_DATA && byte_done && !full_msg) begin
                shadow <= NBITS'({shadow, byte_val});
                bytecnt <= bytecnt + 8'h01;
            end
        end
    end

    // acknowledge: pull data low for the ninth clock of each taken byte
    always_ff @(posedge clk) begin
        if (!resetn) begin
            ack_drive <= 1'b0;
        end else if (start_ev || stop_ev) begin
            ack_drive <= 1'b0;
        end else if (state == RX_ACK && sck_fall) begin
            ack_drive <= ~ack_drive;
        end
    end

    // ----------------------------------------
    // frame timing
    // ----------------------------------------
    localparam int SW = $clog2(SLOT_CYC);
    logic [SW-1:0] slot_cnt;
    logic [2:0] slot;
    wire logic slot_end = slot_cnt == SW'(SLOT_CYC - 1);
    wire logic frame_end = slot_end &&
        slot == 3'(`SLOT_PER_FRAME - 1);
    always_ff @(posedge clk) begin
        if (!resetn) begin
            slot_cnt <= '0;
            slot <= 3'h0;
        end else begin
            slot_cnt <= slot_end ? '0 : slot_cnt + SW'(1);
            if (slot_end) begin
                slot <= frame_end ? 3'h0 : slot + 3'h1;
            end
        end
    end

    // ----------------------------------------
    // display copy: held until a new full message lands
    // ----------------------------------------
    always_ff @(posedge clk) begin
        if (!resetn) begin
            msg_done <= 1'b0;
            active <= '1;
        end else begin
            if (stop_ev && full_msg && state != RX_SKIP) begin
                msg_done <= 1'b1;
            end else if (frame_end) begin
                msg_done <= 1'b0;
            end
            if (frame_end && msg_done) begin
                active <= shadow;
            end
        end
    end

    // ----------------------------------------
    // backplanes: each owns two slots, staircase through four levels
    // ----------------------------------------
    wire logic [1:0] cur_bp = 2'(slot >> 1);
    wire logic inv_half = slot[0];
    genvar g;
    generate
        for (g = 0; g < `NUM_BP; g++) begin : g_bp
            wire logic own = cur_bp == 2'(g);
            wire level_t next_bp = own ?
                (inv_half ? `LVL_5V0 : `LVL_0V5) :
                (inv_half ? `LVL_3V5 : `LVL_2V0);
            always_ff @(posedge clk) begin
                if (!resetn) begin
                    bp_level[g] <= `LVL_2V0;
                end else begin
                    bp_level[g] <= next_bp;
                end
            end
        end
        for (g = 0; g < NSEG; g++) begin : g_seg
            seg_wave u_seg (
                .clk(clk),
                .resetn(resetn),
                .seg_on(active[3*g +: 3]),
                .bp_idx(cur_bp),
                .inv_half(inv_half),
                .level(seg_level[g])
            );
        end
    endgenerate

    // open-drain data pin, registered
    always_ff @(posedge clk) begin
        if (!resetn) begin
            bus_out <= '0;
        end else begin
            bus_out.data_out <= 1'b0;
            bus_out.data_oe <= ack_drive;
        end
    end
endmodule : lcd_seg_driver

// ===== dv/lcd_seg_checker.sv
// port checker for the lcd segment driver
`timescale 1ns/100ps
`include "lcd_drv_params.svh"
module lcd_seg_checker #(
    parameter int NSEG = 40, // segment outputs
    parameter int FRAME_HZ = 50 // frame rate
) (
    input wire logic clk, // system clock
    input wire logic resetn, // sync reset, active low
    input wire lcd_drv_pkg::bus_in_t bus_in, // bus pins
    input wire lcd_drv_pkg::bus_out_t bus_out, // ack drive
    input wire lcd_drv_pkg::level_t bp_level [`NUM_BP], // backplanes
    input wire lcd_drv_pkg::level_t seg_level [NSEG] // segments
);
    import lcd_drv_pkg::*;
    localparam int SLOT = `CLK_HZ / (FRAME_HZ * `SLOT_PER_FRAME);
    default clocking @(posedge clk); endclocking
    default disable iff (!resetn);
    level_t last0; // backplane 0 one cycle ago
    logic seen; // first step seen, so reset values are gone
    logic [31:0] run; // cycles since backplane 0 stepped
    logic [7:0] idle; // cycles the bus clock stood high
    wire moved = bp_level[0] != last0;
    // slot timer restarts on every backplane step
    always_ff @(posedge clk) begin
        last0 <= bp_level[0];
        seen <= resetn && (seen || moved);
        run <= (!resetn || moved) ? 32'h0 : run + 32'h1;
        idle <= (!resetn || !bus_in.clk_line) ? 8'h0 :
            idle + {7'h0, idle != 8'hff};
    end
    owner_one_a: assert property (seen |-> $onehot({
        bp_level[0][1] == bp_level[0][0], bp_level[1][1] == bp_level[1][0],
        bp_level[2][1] == bp_level[2][0]})) else $error("owner count");
    slot_len_a: assert property (seen && moved |-> run == SLOT - 1)
        else $error("slot length");
    stair_step_a: assert property (last0 == `LVL_0V5 && moved |->
        bp_level[0] == `LVL_5V0) else $error("staircase order");
    phase_next_a: assert property (last0 == `LVL_5V0 && moved |->
        bp_level[1] == `LVL_0V5) else $error("phase 0 to 1");
    phase_wrap_a: assert property ($past(bp_level[2]) == `LVL_5V0 &&
        bp_level[2] != `LVL_5V0 |-> bp_level[0] == `LVL_0V5)
        else $error("phase 2 to 0");
    ack_hold_a: assert property ($rose(bus_out.data_oe) |->
        bus_out.data_oe [*6] ##[1:4] !bus_out.data_oe) else $error("ack");
    idle_quiet_a: assert property (idle > 8'h0c |->
        !bus_out.data_oe) else $error("ack while idle");
    drive_low_a: assert property (!bus_out.data_out)
        else $error("data pin driven high");
    seg_slot_a: assert property (seen &&
        seg_level[0] != $past(seg_level[0]) |-> moved || $past(moved))
        else $error("segment off slot edge");
endmodule : lcd_seg_checker
bind lcd_seg_driver lcd_seg_checker #(.NSEG(NSEG), .FRAME_HZ(FRAME_HZ))
    i_chk (.clk(clk), .resetn(resetn), .bus_in(bus_in), .bus_out(bus_out),
    .bp_level(bp_level), .seg_level(seg_level));

// ===== dv/host_bus_model.sv
// host model driving the two-wire display bus
`timescale 1ns/100ps
module host_bus_model (
    input wire logic clk, // system clock
    input wire logic data_wire, // resolved data line
    output logic clk_line, // bus clock, stands high when idle
    output logic data_drv, // low sinks the data line
    output int n_ack // acks seen in the last message
);
    logic s; // data line just before the clock fell
    initial begin
        clk_line = 1'b1;
        data_drv = 1'b1;
        n_ack = 0;
    end
    // a quarter bus clock; data moves mid-low so it never races an edge
    task automatic q();
        repeat (2) @(negedge clk);
    endtask : q
    task automatic bit_out(input logic v);
        q();
        data_drv = v;
        q();
        clk_line = 1'b1;
        q();
        q();
        s = data_wire;
        clk_line = 1'b0;
    endtask : bit_out
    // start, address, nb data bytes each with a released ack bit, stop
    task automatic send(input logic [7:0] adr, input logic [119:0] d,
            input int nb);
        n_ack = 0;
        data_drv = 1'b0;
        q();
        q();
        clk_line = 1'b0;
        for (int i = -1; i < nb; i++) begin
            for (int b = 7; b >= 0; b--)
                bit_out(i < 0 ? adr[b] : d[112 - 8 * i + b]);
            bit_out(1'b1);
            n_ack += int'(!s);
        end
        q();
        data_drv = 1'b0;
        q();
        clk_line = 1'b1;
        q();
        data_drv = 1'b1;
        q();
    endtask : send
endmodule : host_bus_model

// ===== dv/testbench.sv
// self-checking bench for the lcd segment driver
`timescale 1ns/100ps
`include "lcd_drv_params.svh"
module testbench;
    import lcd_drv_pkg::*;
    localparam int FHZ = 400000; // shortens a slot to a few cycles
    localparam int SLOT = `CLK_HZ / (FHZ * `SLOT_PER_FRAME);
    localparam logic [119:0] PAT_A = {20{6'h19}};
    localparam logic [119:0] PAT_B = {15{8'hc3}};
    logic clk;
    logic resetn = 1'b0;
    logic bclk;
    logic drv;
    int n_ack;
    int n_fail = 0;
    int comparisons = 0;
    int cycles = 0;
    bus_in_t bus_in;
    bus_out_t bus_out;
    level_t bp_level [`NUM_BP];
    level_t seg_level [`NUM_SEG];
    // pulled-up data line: low while either side sinks it
    assign bus_in.clk_line = bclk;
    assign bus_in.data_line = drv & ~bus_out.data_oe;
    lcd_seg_driver #(.NSEG(`NUM_SEG), .FRAME_HZ(FHZ)) i_dut (.clk(clk),
        .resetn(resetn), .bus_in(bus_in), .bus_out(bus_out),
        .bp_level(bp_level), .seg_level(seg_level));
    host_bus_model i_host (.clk(clk), .data_wire(bus_in.data_line),
        .clk_line(bclk), .data_drv(drv), .n_ack(n_ack));
    initial begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end
    // hang guard, well above the expected run
    always @(posedge clk) begin
        cycles++;
        if (cycles == 40000) begin
            n_fail++;
            tally_and_finish();
        end
    end
    task automatic cmp_lvl(input level_t got, input level_t exp);
        comparisons++;
        if (got !== exp) begin
            n_fail++;
            $display("[FAIL] %0t level %h exp %h", $time, got, exp);
        end
    endtask : cmp_lvl
    task automatic cmp_cnt(input int got, input int exp);
        comparisons++;
        if (got != exp) begin
            n_fail++;
            $display("[FAIL] %0t acks %0d exp %0d", $time, got, exp);
        end
    endtask : cmp_cnt
    // sample mid-slot in both halves of backplane k's own slot pair
    task automatic check_display(input logic [119:0] d);
        for (int k = 0; k < `NUM_BP; k++) begin
            for (int i = 0; i < 200 && bp_level[k] === `LVL_0V5; i++)
                @(negedge clk);
            for (int i = 0; i < 200 && bp_level[k] !== `LVL_0V5; i++)
                @(negedge clk);
            repeat (SLOT / 2) @(negedge clk);
            cmp_lvl(bp_level[k], `LVL_0V5);
            cmp_lvl({1'b0, ^bp_level[(k + 1) % 3]}, 2'h1);
            for (int g = 0; g < `NUM_SEG; g++)
                if (d[3 * g + k]) cmp_lvl(seg_level[g], `LVL_5V0);
                else cmp_lvl({1'b0, ^seg_level[g]}, 2'h1);
            repeat (SLOT) @(negedge clk);
            cmp_lvl(bp_level[k], `LVL_5V0);
            for (int g = 0; g < `NUM_SEG; g++)
                if (d[3 * g + k]) cmp_lvl(seg_level[g], `LVL_0V5);
                else cmp_lvl({1'b0, ^seg_level[g]}, 2'h1);
        end
    endtask : check_display
    task automatic t_reset_lit();
        repeat (4) @(negedge clk);
        check_display({120{1'b1}});
        $display("test reset lit done");
    endtask : t_reset_lit
    task automatic t_no_refresh();
        repeat (30 * SLOT) @(negedge clk);
        check_display(PAT_A);
        $display("test no refresh done");
    endtask : t_no_refresh
    task automatic t_write(input logic [119:0] d);
        i_host.send(`DEV_ADDR, d, 15);
        cmp_cnt(n_ack, 16);
        repeat (12 * SLOT) @(negedge clk);
        check_display(d);
        $display("test write done");
    endtask : t_write
    // refused messages must leave the shown pattern alone
    task automatic t_refused(input logic [7:0] adr, input int nb,
            input int acks);
        i_host.send(adr, PAT_B, nb);
        cmp_cnt(n_ack, acks);
        repeat (12 * SLOT) @(negedge clk);
        check_display(PAT_A);
        $display("test refused done");
    endtask : t_refused
    task automatic tally_and_finish();
        $display("comparisons %0d mismatches %0d", comparisons, n_fail);
        if (n_fail == 0 && comparisons > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask : tally_and_finish
    initial begin
        repeat (20) @(negedge clk);
        resetn = 1'b1;
        t_reset_lit();
        t_write(PAT_A);
        t_no_refresh();
        t_refused(8'h75, 15, 0);
        t_refused(`DEV_ADDR, 14, 15);
        t_write(PAT_B);
        tally_and_finish();
    end
endmodule : testbench
